// ---- cmd_slave_map.vh ----
`ifndef CMD_SLAVE_MAP_VH
`define CMD_SLAVE_MAP_VH

// frame
`define FRAME_LAST_IDX      4'h8
`define FRAME_IDX_ADDR      4'h0
`define FRAME_IDX_CMD       4'h1
`define FRAME_IDX_TYPE      4'h2
`define FRAME_IDX_MOTOR     4'h3

// command numbers
`define CMD_ROTATE_RIGHT    8'h01
`define CMD_ROTATE_LEFT     8'h02
`define CMD_MOTOR_HALT      8'h03
`define CMD_MOVE_TO_TARGET  8'h04
`define CMD_SET_AXIS        8'h05
`define CMD_GET_AXIS        8'h06

// move types
`define MOVE_ABSOLUTE       8'h00
`define MOVE_RELATIVE       8'h01

// reply status codes
`define STATUS_OK           8'h64
`define STATUS_BAD_SUM      8'h01
`define STATUS_BAD_CMD      8'h02
`define STATUS_BAD_TYPE     8'h03
`define STATUS_BAD_VALUE    8'h04
`define STATUS_NOT_AVAIL    8'h06

// axis setting numbers
`define AXIS_RAMP_MAX_SPEED 8'h04
`define AXIS_RAMP_MAX_ACCEL 8'h05
`define AXIS_RUN_CURRENT    8'h06
`define AXIS_IDLE_CURRENT   8'h07

// axis setting ranges and reset values
`define RAMP_MIN            11'h001
`define RAMP_SPEED_RESET    11'h0C8
`define RAMP_ACCEL_RESET    11'h064
`define RUN_CURRENT_RESET   8'h80
`define IDLE_CURRENT_RESET  8'h20

// motion modes
`define MODE_STOP           2'h0
`define MODE_VELOCITY       2'h1
`define MODE_POSITION       2'h2

`endif

// ---- direct_mode_command_slave.v ----
// What this block does
// - execute command fully, then send one reply
// - link stays receiving except while replying
// - never transmit without a received command
// - setting 4 is ramp maximum speed
// - setting 5 is ramp and velocity acceleration
// - setting 6 is running coil current
// - setting 7 is stationary coil current
// - commands arrive in binary encoding
// - nine-byte frame, value sent MSB first
// - checksum is 8-bit sum of preceding bytes
// - status codes 100,1,2,3,4 are sent; code 6 is defined but never sent
`timescale 1ns/10ps
`include "cmd_slave_map.vh"

module direct_mode_command_slave #(
	parameter [7:0] MODULE_ADDR = 8'h01,
	parameter [7:0] REPLY_ADDR  = 8'h02
) (
	input  wire        ref_clk_in,
	input  wire        resetn_in,
	input  wire        ce_in,
	input  wire        rx_valid_in,
	input  wire [7:0]  rx_data_in,
	input  wire        tx_ready_in,
	input  wire        moving_in,
	output reg         tx_valid_out,
	output reg  [7:0]  tx_data_out,
	output reg         drive_en_out,
	output reg  [1:0]  motion_mode_out,
	output reg         direction_out,
	output reg  [31:0] velocity_out,
	output reg  [31:0] target_pos_out,
	output reg         motion_start_out,
	output reg  [10:0] ramp_speed_out,
	output reg  [10:0] ramp_accel_out,
	output reg  [7:0]  coil_current_out
);

	localparam [2:0] ST_RECV = 3'b001;
	localparam [2:0] ST_EXEC = 3'b010;
	localparam [2:0] ST_SEND = 3'b100;
	reg  [2:0]  state_ff;
	reg  [3:0]  idx_ff;
	reg  [7:0]  sum_ff;
	reg  [7:0]  addr_ff;
	reg  [7:0]  cmd_ff;
	reg  [7:0]  type_ff;
	reg  [7:0]  motor_ff;
	reg  [31:0] value_ff;
	reg         sum_ok_ff;
	reg  [7:0]  rep_status_ff;
	reg  [31:0] rep_value_ff;
	reg  [7:0]  rep_sum_ff;
	reg  [7:0]  run_current_ff;
	reg  [7:0]  idle_current_ff;
	reg  [7:0]  nxt_status;
	reg  [31:0] nxt_value;
	function [7:0] byte_sum4;
		input [31:0] v;
		begin
			byte_sum4 = v[31:24] + v[23:16] + v[15:8] + v[7:0];
		end
	endfunction
	function ramp_in_range;
		input [31:0] v;
		begin
			ramp_in_range = (v[31:11] == 21'h00000) && (v[10:0] >= `RAMP_MIN);
		end
	endfunction
	function [7:0] reply_byte;
		input [3:0]  i;
		input [7:0]  status;
		input [7:0]  cmd;
		input [31:0] v;
		input [7:0]  sum;
		begin
			case (i)
				4'h0:    reply_byte = REPLY_ADDR;
				4'h1:    reply_byte = MODULE_ADDR;
				4'h2:    reply_byte = status;
				4'h3:    reply_byte = cmd;
				4'h4:    reply_byte = v[31:24];
				4'h5:    reply_byte = v[23:16];
				4'h6:    reply_byte = v[15:8];
				4'h7:    reply_byte = v[7:0];
				default: reply_byte = sum;
			endcase
		end
	endfunction
	// decide status and reply value of the frame held
	always @*
	begin
		nxt_status = `STATUS_OK;
		nxt_value  = value_ff;
		if (!sum_ok_ff)
			nxt_status = `STATUS_BAD_SUM;
		else
		begin
			case (cmd_ff)
				`CMD_ROTATE_RIGHT, `CMD_ROTATE_LEFT, `CMD_MOTOR_HALT:
					if (motor_ff != 8'h00)
						nxt_status = `STATUS_BAD_VALUE;
				`CMD_MOVE_TO_TARGET:
					if (type_ff != `MOVE_ABSOLUTE && type_ff != `MOVE_RELATIVE)
						nxt_status = `STATUS_BAD_TYPE;
					else if (motor_ff != 8'h00)
						nxt_status = `STATUS_BAD_VALUE;
				`CMD_SET_AXIS, `CMD_GET_AXIS:
				begin
					if (motor_ff != 8'h00)
						nxt_status = `STATUS_BAD_VALUE;
					else
					begin
						case (type_ff)
							`AXIS_RAMP_MAX_SPEED:
							begin
								nxt_value = {21'h00000, ramp_speed_out};
								if (cmd_ff == `CMD_SET_AXIS && !ramp_in_range(value_ff))
									nxt_status = `STATUS_BAD_VALUE;
							end
							`AXIS_RAMP_MAX_ACCEL:
							begin
								nxt_value = {21'h00000, ramp_accel_out};
								if (cmd_ff == `CMD_SET_AXIS && !ramp_in_range(value_ff))
									nxt_status = `STATUS_BAD_VALUE;
							end
							`AXIS_RUN_CURRENT:
							begin
								nxt_value = {24'h000000, run_current_ff};
								if (cmd_ff == `CMD_SET_AXIS && value_ff[31:8] != 24'h000000)
									nxt_status = `STATUS_BAD_VALUE;
							end
							`AXIS_IDLE_CURRENT:
							begin
								nxt_value = {24'h000000, idle_current_ff};
								if (cmd_ff == `CMD_SET_AXIS && value_ff[31:8] != 24'h000000)
									nxt_status = `STATUS_BAD_VALUE;
							end
							default:
								nxt_status = `STATUS_BAD_TYPE;
						endcase
						if (cmd_ff == `CMD_SET_AXIS && nxt_status == `STATUS_OK)
							nxt_value = value_ff;
					end
				end
				default:
					nxt_status = `STATUS_BAD_CMD;
			endcase
		end
	end
	always @(posedge ref_clk_in)
	begin
		if (!resetn_in)
		begin
			state_ff         <= ST_RECV;
			idx_ff           <= 4'h0;
			sum_ff           <= 8'h00;
			addr_ff          <= 8'h00;
			cmd_ff           <= 8'h00;
			type_ff          <= 8'h00;
			motor_ff         <= 8'h00;
			value_ff         <= 32'h00000000;
			sum_ok_ff        <= 1'b0;
			rep_status_ff    <= 8'h00;
			rep_value_ff     <= 32'h00000000;
			rep_sum_ff       <= 8'h00;
			run_current_ff   <= `RUN_CURRENT_RESET;
			idle_current_ff  <= `IDLE_CURRENT_RESET;
			tx_valid_out     <= 1'b0;
			tx_data_out      <= 8'h00;
			drive_en_out     <= 1'b0;
			motion_mode_out  <= `MODE_STOP;
			direction_out    <= 1'b0;
			velocity_out     <= 32'h00000000;
			target_pos_out   <= 32'h00000000;
			motion_start_out <= 1'b0;
			ramp_speed_out   <= `RAMP_SPEED_RESET;
			ramp_accel_out   <= `RAMP_ACCEL_RESET;
			coil_current_out <= `IDLE_CURRENT_RESET;
		end
		else if (ce_in)
		begin
			motion_start_out <= 1'b0;
			// current follows motion state
			coil_current_out <= moving_in ? run_current_ff : idle_current_ff;
			case (state_ff)
				ST_RECV:
				begin
					drive_en_out <= 1'b0;
					if (rx_valid_in)
					begin
						case (idx_ff)
							`FRAME_IDX_ADDR:  addr_ff  <= rx_data_in;
							`FRAME_IDX_CMD:   cmd_ff   <= rx_data_in;
							`FRAME_IDX_TYPE:  type_ff  <= rx_data_in;
							`FRAME_IDX_MOTOR: motor_ff <= rx_data_in;
							`FRAME_LAST_IDX:  sum_ok_ff <= (rx_data_in == sum_ff);
							default:          value_ff <= {value_ff[23:0], rx_data_in};
						endcase
						if (idx_ff == `FRAME_LAST_IDX)
						begin
							idx_ff <= 4'h0;
							sum_ff <= 8'h00;
							// frames for other nodes get no reply
							if (addr_ff == MODULE_ADDR)
								state_ff <= ST_EXEC;
						end
						else
						begin
							idx_ff <= idx_ff + 4'h1;
							sum_ff <= sum_ff + rx_data_in;
						end
					end
				end
				ST_EXEC:
				begin
					if (nxt_status == `STATUS_OK)
					begin
						case (cmd_ff)
							`CMD_ROTATE_RIGHT, `CMD_ROTATE_LEFT:
							begin
								motion_mode_out  <= `MODE_VELOCITY;
								direction_out    <= (cmd_ff == `CMD_ROTATE_RIGHT);
								velocity_out     <= value_ff;
								motion_start_out <= 1'b1;
							end
							`CMD_MOTOR_HALT:
							begin
								motion_mode_out  <= `MODE_STOP;
								velocity_out     <= 32'h00000000;
								motion_start_out <= 1'b1;
							end
							`CMD_MOVE_TO_TARGET:
							begin
								motion_mode_out  <= `MODE_POSITION;
								motion_start_out <= 1'b1;
								if (type_ff == `MOVE_ABSOLUTE)
									target_pos_out <= value_ff;
								else
									target_pos_out <= target_pos_out + value_ff;
							end
							`CMD_SET_AXIS:
								case (type_ff)
									`AXIS_RAMP_MAX_SPEED: ramp_speed_out  <= value_ff[10:0];
									`AXIS_RAMP_MAX_ACCEL: ramp_accel_out  <= value_ff[10:0];
									`AXIS_RUN_CURRENT:    run_current_ff  <= value_ff[7:0];
									`AXIS_IDLE_CURRENT:   idle_current_ff <= value_ff[7:0];
									default:              ramp_speed_out  <= ramp_speed_out;
								endcase
							default:
								motion_mode_out <= motion_mode_out;
						endcase
					end
					rep_status_ff <= nxt_status;
					rep_value_ff  <= nxt_value;
					rep_sum_ff    <= REPLY_ADDR + MODULE_ADDR + nxt_status + cmd_ff
						+ byte_sum4(nxt_value);
					idx_ff        <= 4'h0;
					state_ff      <= ST_SEND;
				end
				ST_SEND:
				begin
					drive_en_out <= 1'b1;
					if (!tx_valid_out)
					begin
						tx_valid_out <= 1'b1;
						tx_data_out  <= reply_byte(idx_ff, rep_status_ff, cmd_ff,
							rep_value_ff, rep_sum_ff);
					end
					else if (tx_ready_in)
					begin
						if (idx_ff == `FRAME_LAST_IDX)
						begin
							tx_valid_out <= 1'b0;
							drive_en_out <= 1'b0;
							idx_ff       <= 4'h0;
							state_ff     <= ST_RECV;
						end
						else
						begin
							idx_ff      <= idx_ff + 4'h1;
							tx_data_out <= reply_byte(idx_ff + 4'h1, rep_status_ff, cmd_ff,
								rep_value_ff, rep_sum_ff);
						end
					end
				end
				default:
					state_ff <= ST_RECV;
			endcase
		end
	end

endmodule // direct_mode_command_slave

// ---- cmd_slave_properties.sv ----
`timescale 1ns/10ps
module cmd_slave_properties #(
	parameter [7:0] MODULE_ADDR = 8'h01,
	parameter [7:0] REPLY_ADDR  = 8'h02
) (
	input wire        ref_clk_in,
	input wire        resetn_in,
	input wire        ce_in,
	input wire        rx_valid_in,
	input wire        tx_ready_in,
	input wire        moving_in,
	input wire        tx_valid_out,
	input wire [7:0]  tx_data_out,
	input wire        drive_en_out,
	input wire        motion_start_out,
	input wire [10:0] ramp_speed_out,
	input wire [10:0] ramp_accel_out,
	input wire [7:0]  coil_current_out
);
	reg [3:0] sent_ff;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	// reply bytes accepted so far
	always @(posedge ref_clk_in)
		if (!resetn_in)
			sent_ff <= 4'h0;
		else if (ce_in && tx_valid_out && tx_ready_in)
			sent_ff <= (sent_ff == 4'h8) ? 4'h0 : sent_ff + 4'h1;
	sequence reply_head;
		tx_data_out == REPLY_ADDR ##1 tx_data_out == MODULE_ADDR;
	endsequence
	a_drive_while_reply: assert property (drive_en_out == tx_valid_out)
		else $error("driver enable differs from reply valid");
	a_reply_solicited: assert property ($rose(tx_valid_out) |-> $past(rx_valid_in, 3))
		else $error("reply started without a frame");
	a_reply_holds: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
		else $error("reply byte dropped");
	a_reply_header: assert property ($rose(tx_valid_out) && tx_ready_in |-> reply_head)
		else $error("reply header wrong");
	a_reply_length: assert property (tx_valid_out && tx_ready_in |=> tx_valid_out == (sent_ff != 4'h0))
		else $error("reply length wrong");
	a_speed_on_exec: assert property ($changed(ramp_speed_out) && $past(resetn_in) |-> $past(rx_valid_in, 2))
		else $error("speed changed without command");
	a_accel_on_exec: assert property ($changed(ramp_accel_out) && $past(resetn_in) |-> $past(rx_valid_in, 2))
		else $error("accel changed without command");
	a_coil_cause: assert property ($changed(coil_current_out) && $past(resetn_in, 2) |-> $past(moving_in) != $past(moving_in, 2) || $past(rx_valid_in, 3))
		else $error("coil current changed without cause");
	a_start_pulse: assert property (motion_start_out |-> $past(rx_valid_in, 2) ##1 !motion_start_out)
		else $error("start pulse wrong");
endmodule // cmd_slave_properties

bind direct_mode_command_slave cmd_slave_properties #(
	.MODULE_ADDR(MODULE_ADDR),
	.REPLY_ADDR(REPLY_ADDR)
) u_props (.ref_clk_in, .resetn_in, .ce_in, .rx_valid_in, .tx_ready_in, .moving_in,
	.tx_valid_out, .tx_data_out, .drive_en_out, .motion_start_out, .ramp_speed_out,
	.ramp_accel_out, .coil_current_out);

// ---- host_link_model.sv ----
`timescale 1ns/10ps
module host_link_model (
	input  wire       clk_in,
	input  wire       tx_valid_in,
	input  wire [7:0] tx_data_in,
	output reg        rx_valid_out,
	output reg  [7:0] rx_data_out,
	output reg        tx_ready_out
);
	initial
	begin
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
		tx_ready_out = 1'b0;
	end
	// one frame out, then collect the reply before returning
	task xfer(input [71:0] frame, input slow, output [71:0] rep, output [3:0] n);
		integer i;
		begin
			rep = 72'h0;
			n = 4'h0;
			for (i = 0; i < 9; i = i + 1)
			begin
				@(posedge clk_in);
				#1;
				rx_valid_out = 1'b1;
				rx_data_out = frame[71 - 8 * i -: 8];
			end
			@(posedge clk_in);
			#1;
			rx_valid_out = 1'b0;
			rx_data_out = ~rx_data_out;
			for (i = 0; i < 40 && n < 4'h9; i = i + 1)
			begin
				tx_ready_out = !slow || i[0];
				@(posedge clk_in);
				if (tx_valid_in && tx_ready_out)
				begin
					rep = {rep[63:0], tx_data_in};
					n = n + 4'h1;
				end
				#1;
			end
			tx_ready_out = 1'b0;
		end
	endtask
endmodule // host_link_model

// ---- tb_top.sv ----
`timescale 1ns/10ps
`include "cmd_slave_map.vh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module tb_top;
	reg         ref_clk_in = 1'b0;
	reg         resetn_in = 1'b0;
	reg         ce_in = 1'b1;
	reg         moving_in = 1'b0;
	wire        rx_valid_in, tx_ready_in, tx_valid_out, drive_en_out, direction_out;
	wire        motion_start_out;
	wire [7:0]  rx_data_in, tx_data_out, coil_current_out;
	wire [1:0]  motion_mode_out;
	wire [31:0] velocity_out, target_pos_out;
	wire [10:0] ramp_speed_out, ramp_accel_out;
	integer     seed = 99644, n_mismatch = 0, checked = 0, cyc = 0, i;
	reg  [31:0] st [4:7];
	reg  [31:0] v, e;
	reg  [7:0]  k;
	reg  [71:0] rep;
	reg  [3:0]  n;
	direct_mode_command_slave dut (.ref_clk_in, .resetn_in, .ce_in, .rx_valid_in, .rx_data_in,
		.tx_ready_in, .moving_in, .tx_valid_out, .tx_data_out, .drive_en_out, .motion_mode_out,
		.direction_out, .velocity_out, .target_pos_out, .motion_start_out, .ramp_speed_out,
		.ramp_accel_out, .coil_current_out);
	host_link_model host (.clk_in(ref_clk_in), .tx_valid_in(tx_valid_out),
		.tx_data_in(tx_data_out), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
		.tx_ready_out(tx_ready_in));
	always #2 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in)
		if (++cyc == 6000)
		begin
			n_mismatch++;
			end_of_test;
		end
	function [71:0] frm(input [7:0] a, c, t, m, input [31:0] d);
		reg [63:0] b;
		begin
			b = {a, c, t, m, d};
			frm = {b, b[63:56] + b[55:48] + b[47:40] + b[39:32] + b[31:24] + b[23:16] +
				b[15:8] + b[7:0]};
		end
	endfunction
	task cmd(input [7:0] c, t, m, input [31:0] d, input [7:0] s, input [31:0] x);
		begin
			host.xfer(frm(8'h01, c, t, m, d), 1'($random(seed)), rep, n);
			`CHK("reply", frm(8'h02, 8'h01, s, c, x), rep)
		end
	endtask
	task end_of_test;
		begin
			$display("checked %0d mismatches %0d", checked, n_mismatch);
			if (n_mismatch == 0 && checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial
	begin
		st[4] = `RAMP_SPEED_RESET;
		st[5] = `RAMP_ACCEL_RESET;
		st[6] = `RUN_CURRENT_RESET;
		st[7] = `IDLE_CURRENT_RESET;
		repeat (20) @(posedge ref_clk_in);
		#1 resetn_in = 1'b1;
		for (i = 0; i < 24; i = i + 1)
		begin
			k = 8'h04 + i % 4;
			e = k < 8'h06 ? 32'h7FF : 32'hFF;
			v = i < 4 ? e : i < 8 ? e + 1 : i < 10 ? 0 : $random(seed) & 32'hFFF;
			e = (v <= e && (v != 0 || k > 8'h05)) ? v : st[k];
			cmd(`CMD_SET_AXIS, k, 8'h00, v, e == v ? `STATUS_OK : `STATUS_BAD_VALUE, e);
			st[k] = e;
			cmd(`CMD_GET_AXIS, k, 8'h00, 32'h0, `STATUS_OK, e);
			`CHK("speed", st[4][10:0], ramp_speed_out)
			`CHK("accel", st[5][10:0], ramp_accel_out)
			moving_in = 1'($random(seed));
			repeat (2) @(posedge ref_clk_in);
			#1 `CHK("coil", moving_in ? st[6][7:0] : st[7][7:0], coil_current_out)
		end
		// clock enable low must hold the coil current through a motion change
		ce_in = 1'b0;
		moving_in = !moving_in;
		repeat (2) @(posedge ref_clk_in);
		#1 `CHK("frozen", moving_in ? st[7][7:0] : st[6][7:0], coil_current_out)
		moving_in = !moving_in;
		ce_in = 1'b1;
		$display("settings test done");
		host.xfer(frm(8'h01, `CMD_SET_AXIS, 8'h04, 8'h00, 32'h5) ^ 72'h1, 1'b0, rep, n);
		`CHK("bad sum", frm(8'h02, 8'h01, `STATUS_BAD_SUM, `CMD_SET_AXIS, 32'h5), rep)
		`CHK("kept", st[4][10:0], ramp_speed_out)
		cmd(8'h09, 8'h00, 8'h00, 32'h3, `STATUS_BAD_CMD, 32'h3);
		cmd(`CMD_SET_AXIS, 8'h08, 8'h00, 32'h3, `STATUS_BAD_TYPE, 32'h3);
		cmd(`CMD_GET_AXIS, 8'h04, 8'h01, 32'h3, `STATUS_BAD_VALUE, 32'h3);
		cmd(`CMD_MOVE_TO_TARGET, 8'h02, 8'h00, 32'h3, `STATUS_BAD_TYPE, 32'h3);
		host.xfer(frm(8'h07, `CMD_GET_AXIS, 8'h04, 8'h00, 32'h0), 1'b0, rep, n);
		`CHK("silent", 4'h0, n)
		$display("error test done");
		v = $random(seed);
		cmd(`CMD_ROTATE_RIGHT, 8'h00, 8'h00, v, `STATUS_OK, v);
		`CHK("right", {`MODE_VELOCITY, 1'b1, v}, {motion_mode_out, direction_out, velocity_out})
		cmd(`CMD_ROTATE_LEFT, 8'h00, 8'h00, v, `STATUS_OK, v);
		`CHK("left", {`MODE_VELOCITY, 1'b0, v}, {motion_mode_out, direction_out, velocity_out})
		cmd(`CMD_MOVE_TO_TARGET, `MOVE_ABSOLUTE, 8'h00, v, `STATUS_OK, v);
		`CHK("abs", {`MODE_POSITION, v}, {motion_mode_out, target_pos_out})
		cmd(`CMD_MOVE_TO_TARGET, `MOVE_RELATIVE, 8'h00, 32'h10, `STATUS_OK, 32'h10);
		`CHK("rel", v + 32'h10, target_pos_out)
		cmd(`CMD_MOTOR_HALT, 8'h00, 8'h00, v, `STATUS_OK, v);
		`CHK("halt", {`MODE_STOP, 32'h0}, {motion_mode_out, velocity_out})
		$display("motion test done");
		end_of_test;
	end
endmodule // tb_top
